/* File: exc_cfg.svh */
// Offsets, field positions, reset values and vector constants for exception entry
`ifndef EXC_CFG_SVH
`define EXC_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define RA_MSTATE 8'h00
`define RA_SRADDR 8'h04
`define RA_SRSTATE 8'h08
`define RA_DBGCTL 8'h0C
`define RA_STATUS 8'h10

// ----------------------------------------------------------------
// Machine state bit positions (vector index = 31 - printed bit)
// ----------------------------------------------------------------
`define MS_ILE 16
`define MS_EE 15
`define MS_PR 14
`define MS_FP 13
`define MS_ME 12
`define MS_FE0 11
`define MS_SE 10
`define MS_BE 9
`define MS_FE1 8
`define MS_IP 6
`define MS_RI 1
`define MS_LE 0

// Writable bits; reserved bits read as zero
`define MS_WMASK 32'h0001_FF43
// Bits cleared on every non-reset entry
`define MS_CLRMASK 32'h0000_EF02
// Reset value apart from the strapped vector base bit
`define MS_RSTVAL 32'h0000_1000

// ----------------------------------------------------------------
// Vector table bases and offsets
// ----------------------------------------------------------------
`define VB_LOW 32'h0000_0000
`define VB_HIGH 32'hFFF0_0000
`define VO_RESET 32'h0000_0100
`define VO_MCHK 32'h0000_0200
`define VO_EXT 32'h0000_0500
`define VO_DECR 32'h0000_0900
`define VO_TRACE 32'h0000_0D00
`define VO_BRK 32'h0000_1C00
`define VO_NMIBRK 32'h0000_1F00

`endif

/* File: exc_pick.sv */
// Fixed-priority picker over exception requests
`timescale 1ns/1ps
`default_nettype none
module exc_pick #(
    parameter int N = 7,
    parameter int W = 3
) (
    input  wire logic [N-1:0] req_in,
    output logic              any_out,
    output logic [W-1:0]      idx_out
);
    // Lowest index wins; scanning downward keeps the last hit
    always_comb begin
        any_out = 1'b0;
        idx_out = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_in[i]) begin
                any_out = 1'b1;
                idx_out = W'(i);
            end
        end
    end
endmodule
`default_nettype wire

/* File: exc_pkg.sv */
// Types shared by the exception entry logic
`default_nettype none
package exc_pkg;

    // ----------------------------------------------------------------
    // Sequencer states and exception kinds
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_VECT = 2'h1,
        ST_RST  = 2'h2,
        ST_STOP = 2'h3
    } ent_state_e;

    // Code order is also the picker's priority order, lowest code first; K_RESET is never picked
    typedef enum logic [2:0] {
        K_NMIBRK = 3'h0,
        K_MCHK   = 3'h1,
        K_INSTR  = 3'h2,
        K_TRACE  = 3'h3,
        K_BRK    = 3'h4,
        K_EXT    = 3'h5,
        K_DECR   = 3'h6,
        K_RESET  = 3'h7
    } exc_kind_e;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_s;

    typedef struct packed {
        logic ext_irq;
        logic decr;
        logic mchk;
        logic nmi_brk;
        logic ext_brk;
        logic int_brk;
        logic fp_exc;
        logic instr_exc;
        logic instr_done;
        logic earlier_pend;
        logic reservation;
    } cond_s;

    typedef struct packed {
        ent_state_e  st;
        exc_kind_e   kind;
        logic [31:0] msr;
        logic [31:0] save_resume_addr;
        logic [31:0] save_resume_state;
        logic [31:0] vec;
        logic        unmask;
        logic        tpend;
        logic        fetch;
        logic        take;
        logic        resv;
        logic        stop;
        logic        fpp;
        logic [31:0] rdata;
    } core_state_s;

endpackage
`default_nettype wire

/* File: exception_entry_control.sv */
// Exception entry control: machine state, save/restore and vectoring
//
// What this block does
// - Machine check taken only while enable set
// - Single-step trace after clean instruction
// - Single-step forces strict program order
// - Vector base select picks low/high table
// - Recoverable flag marks exception recoverability
// - Normal byte order bit selects endianness
// - Float modes zero disable, else precise
// - Saved state written before handler fetch
// - External/decrementer held while enable clear
// - Entry clears external interrupt enable
// - Masked machine check enters checkstop
// - Reset, unmaskable breakpoint never masked
// - Debug select bit sets breakpoint maskability
// - Maskable breakpoints need recoverable flag
// - Earlier exceptions handled and enabled first
// - Save address and state on entry
// - New state governs handler from fetch
// - Handler address is base plus offset
// - Reset and entry machine state values
// - Reservation gets special handling on entry
// - Entry copies handler order into normal
// - Reset strap sets vector base select
// - Unlisted bits unchanged across entry
`timescale 1ns/1ps
`include "exc_cfg.svh"
`default_nettype none
module exception_entry_control (
    input  wire logic             clk_sys_in,
    input  wire logic             srst_in,
    input  wire exc_pkg::bus_req_s bus_in,
    output logic [31:0]           rdata_out,
    input  wire exc_pkg::cond_s   cond_in,
    input  wire logic [31:0]      fault_pc_in,
    input  wire logic [31:0]      next_pc_in,
    input  wire logic [31:0]      instr_vec_off_in,
    input  wire logic [15:0]      exc_info_in,
    input  wire logic             cfg_vector_high_in,
    output logic                  taken_out,
    output logic                  handler_fetch_out,
    output logic [31:0]           handler_addr_out,
    output logic                  resv_clear_out,
    output logic                  checkstop_out,
    output logic [31:0]           msr_out,
    output logic                  program_order_out,
    output logic                  little_endian_out,
    output logic                  fp_precise_out,
    output logic                  user_level_out,
    output logic                  ext_irq_enable_out
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    exc_pkg::core_state_s state_reg;
    exc_pkg::core_state_s state_next;

    logic [6:0]  req;
    logic        req_any;
    logic [2:0]  req_idx;
    logic [31:0] msr_ent;
    logic        stop_cond;
    logic        held;

    // ----------------------------------------------------------------
    // Request gating
    // ----------------------------------------------------------------
    // Each maskable condition passes only when its own enable allows it
    always_comb begin
        req = 7'h00;
        // Unmaskable breakpoints bypass every enable bit
        req[0] = cond_in.nmi_brk |
                 (cond_in.int_brk & state_reg.unmask);
        req[1] = cond_in.mchk & state_reg.msr[`MS_ME];
        // Float conditions only count in precise mode
        req[2] = cond_in.instr_exc |
                 (cond_in.fp_exc &
                  (state_reg.msr[`MS_FE0] | state_reg.msr[`MS_FE1]));
        req[3] = state_reg.tpend;
        // Maskable breakpoints are only safe to take when recoverable
        req[4] = ((cond_in.int_brk & ~state_reg.unmask) | cond_in.ext_brk) &
                 state_reg.msr[`MS_RI];
        req[5] = cond_in.ext_irq & state_reg.msr[`MS_EE];
        req[6] = cond_in.decr & state_reg.msr[`MS_EE];
    end

    // Checkstop wins over every picked request and the hold once the machine check is masked
    assign stop_cond = cond_in.mchk & ~state_reg.msr[`MS_ME];

    // Earlier instruction exceptions still in flight hold every entry except reset and checkstop
    assign held = cond_in.earlier_pend;

    exc_pick #(
        .N(7),
        .W(3)
    ) u_pick (
        .req_in  (req),
        .any_out (req_any),
        .idx_out (req_idx)
    );

    // On reset the strap is sampled while srst_in is high
    msr_entry u_msr (
        .is_reset_in   (srst_in),
        .strap_high_in (cfg_vector_high_in),
        .old_in        (state_reg.msr),
        .new_out       (msr_ent)
    );

    // ----------------------------------------------------------------
    // Vector offset per kind
    // ----------------------------------------------------------------
    function automatic logic [31:0] vec_off(
        input exc_pkg::exc_kind_e k,
        input logic [31:0]        instr_off
    );
        logic [31:0] o;
        o = 32'h0000_0000;
        case (k)
            exc_pkg::K_RESET: begin
                o = `VO_RESET;
            end
            exc_pkg::K_NMIBRK: begin
                o = `VO_NMIBRK;
            end
            exc_pkg::K_MCHK: begin
                o = `VO_MCHK;
            end
            // Instruction-caused kinds carry their own offset
            exc_pkg::K_INSTR: begin
                o = instr_off;
            end
            exc_pkg::K_TRACE: begin
                o = `VO_TRACE;
            end
            exc_pkg::K_BRK: begin
                o = `VO_BRK;
            end
            exc_pkg::K_EXT: begin
                o = `VO_EXT;
            end
            exc_pkg::K_DECR: begin
                o = `VO_DECR;
            end
            default: begin
                o = 32'h0000_0000;
            end
        endcase
        return o;
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        state_next       = state_reg;
        state_next.fetch = 1'b0;
        state_next.take  = 1'b0;
        state_next.resv  = 1'b0;
        state_next.rdata = 32'h0000_0000;

        // Register reads: data stands only in the following cycle
        if (bus_in.rd) begin
            case (bus_in.addr)
                `RA_MSTATE: begin
                    state_next.rdata = state_reg.msr;
                end
                `RA_SRADDR: begin
                    state_next.rdata = state_reg.save_resume_addr;
                end
                `RA_SRSTATE: begin
                    state_next.rdata = state_reg.save_resume_state;
                end
                `RA_DBGCTL: begin
                    state_next.rdata = {31'h0000_0000, state_reg.unmask};
                end
                `RA_STATUS: begin
                    state_next.rdata = {25'h000_0000, state_reg.kind,
                                        state_reg.st, state_reg.tpend,
                                        state_reg.stop};
                end
                default: begin
                    state_next.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Register writes; entry hardware below overrides them
        if (bus_in.wr) begin
            case (bus_in.addr)
                `RA_MSTATE: begin
                    state_next.msr = bus_in.wdata & `MS_WMASK;
                end
                `RA_SRADDR: begin
                    state_next.save_resume_addr = bus_in.wdata;
                end
                `RA_SRSTATE: begin
                    state_next.save_resume_state = bus_in.wdata;
                end
                `RA_DBGCTL: begin
                    state_next.unmask = bus_in.wdata[0];
                end
                default: begin
                end
            endcase
        end

        // Entry sequencer
        case (state_reg.st)
            exc_pkg::ST_RST: begin
                // Reset entry saves nothing and vectors straight away
                state_next.kind  = exc_pkg::K_RESET;
                state_next.st    = exc_pkg::ST_VECT;
            end
            exc_pkg::ST_IDLE: begin
                if (stop_cond) begin
                    state_next.st   = exc_pkg::ST_STOP;
                    state_next.stop = 1'b1;
                end else if (req_any && !held) begin
                    state_next.kind = exc_pkg::exc_kind_e'(req_idx);
                    // Asynchronous kinds resume at the next instruction
                    if (req_idx == 3'h2) begin
                        state_next.save_resume_addr = fault_pc_in;
                    end else begin
                        state_next.save_resume_addr = next_pc_in;
                    end
                    // Saved one cycle ahead of the handler fetch
                    state_next.save_resume_state = {exc_info_in,
                                       state_reg.msr[15:0]};
                    state_next.take = 1'b1;
                    // Any live reservation is dropped on entry
                    state_next.resv = cond_in.reservation;
                    if (req_idx == 3'h3) begin
                        state_next.tpend = 1'b0;
                    end
                    state_next.st = exc_pkg::ST_VECT;
                end
            end
            exc_pkg::ST_VECT: begin
                // Reset state is already loaded; others get the entry value
                if (state_reg.kind != exc_pkg::K_RESET) begin
                    state_next.msr = msr_ent;
                end
                // Base bit is unchanged by entry, so old and new agree
                state_next.vec = (state_reg.msr[`MS_IP] ? `VB_HIGH : `VB_LOW) +
                                 vec_off(state_reg.kind,
                                         instr_vec_off_in);
                state_next.fetch = 1'b1;
                state_next.st    = exc_pkg::ST_IDLE;
            end
            exc_pkg::ST_STOP: begin
                // Only a reset leaves checkstop
                state_next.stop = 1'b1;
            end
            default: begin
                state_next.st = exc_pkg::ST_IDLE;
            end
        endcase

        // Trace arms after a clean completion; arming wins over taking
        if (state_reg.msr[`MS_SE] && cond_in.instr_done &&
            !cond_in.instr_exc) begin
            state_next.tpend = 1'b1;
        end

        // Mode outputs follow the final machine state value
        state_next.fpp = state_next.msr[`MS_FE0] |
                         state_next.msr[`MS_FE1];

        // Synchronous reset: strap is caught here, not at an async edge
        if (srst_in) begin
            state_next        = '0;
            state_next.st     = exc_pkg::ST_RST;
            state_next.kind   = exc_pkg::K_RESET;
            state_next.msr    = msr_ent;
            state_next.fpp    = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Reset is folded into the next-state logic above
    always_ff @(posedge clk_sys_in) begin
        state_reg <= state_next;
    end

    // ----------------------------------------------------------------
    // Outputs, each a flop bit or word
    // ----------------------------------------------------------------
    assign rdata_out          = state_reg.rdata;
    assign taken_out          = state_reg.take;
    assign handler_fetch_out  = state_reg.fetch;
    assign handler_addr_out   = state_reg.vec;
    assign resv_clear_out     = state_reg.resv;
    assign checkstop_out      = state_reg.stop;
    assign msr_out            = state_reg.msr;
    // Dispatch unit must not reorder while stepping
    assign program_order_out  = state_reg.msr[`MS_SE];
    assign little_endian_out  = state_reg.msr[`MS_LE];
    assign fp_precise_out     = state_reg.fpp;
    assign user_level_out     = state_reg.msr[`MS_PR];
    assign ext_irq_enable_out = state_reg.msr[`MS_EE];

endmodule
`default_nettype wire

/* File: exception_entry_control_checker.sv */
// Port-level assertions for the exception entry control block
`timescale 1ns/1ps
`include "exc_cfg.svh"
`default_nettype none
module exception_entry_control_checker (
    input wire logic           clk_sys_in,
    input wire logic           srst_in,
    input wire exc_pkg::cond_s cond_in,
    input wire logic           taken_out,
    input wire logic           handler_fetch_out,
    input wire logic [31:0]    handler_addr_out,
    input wire logic           resv_clear_out,
    input wire logic           checkstop_out,
    input wire logic [31:0]    msr_out,
    input wire logic           user_level_out,
    input wire logic           program_order_out,
    input wire logic           fp_precise_out,
    input wire logic           ext_irq_enable_out
);
    // ------------------------------------------------
    // Helper state
    // ------------------------------------------------
    logic [1:0]  rst_reg;
    logic [31:0] prev_msr_reg;
    logic        idle_ok;

    // Old machine state and a two-deep reset trail, covering the reset vector cycle
    always_ff @(posedge clk_sys_in) begin
        rst_reg      <= {rst_reg[0], srst_in};
        prev_msr_reg <= msr_out;
    end

    // Idle and free to take: not just out of reset, not mid-entry, not stopped
    assign idle_ok = rst_reg == 2'b00 && !taken_out && !handler_fetch_out && !checkstop_out
                     && !cond_in.earlier_pend;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (srst_in);

    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    property p_fetch_follows;
        taken_out |=> handler_fetch_out && !taken_out;
    endproperty
    property p_ee_cleared;
        handler_fetch_out |-> !ext_irq_enable_out;
    endproperty
    property p_supervisor;
        handler_fetch_out |-> !user_level_out && !program_order_out && !fp_precise_out
            && !msr_out[`MS_RI] && !msr_out[`MS_BE] && !msr_out[`MS_FP];
    endproperty
    property p_vector_base;
        handler_fetch_out |-> handler_addr_out[31:20] == (msr_out[`MS_IP] ? 12'hFFF : 12'h000);
    endproperty
    property p_kept_bits;
        handler_fetch_out |-> msr_out[`MS_ME] == prev_msr_reg[`MS_ME]
            && msr_out[`MS_IP] == prev_msr_reg[`MS_IP]
            && msr_out[`MS_ILE] == prev_msr_reg[`MS_ILE];
    endproperty
    property p_order_copy;
        handler_fetch_out |-> msr_out[`MS_LE] == prev_msr_reg[`MS_ILE];
    endproperty
    property p_nmi_taken;
        idle_ok && cond_in.nmi_brk && !cond_in.mchk |=> taken_out;
    endproperty
    property p_mchk_taken;
        idle_ok && cond_in.mchk && msr_out[`MS_ME] |=> taken_out;
    endproperty
    property p_checkstop_entry;
        idle_ok && cond_in.mchk && !msr_out[`MS_ME] |=> checkstop_out && !taken_out;
    endproperty
    property p_checkstop_sticky;
        checkstop_out |=> checkstop_out && !taken_out;
    endproperty
    property p_earlier_blocks;
        cond_in.earlier_pend |=> !taken_out;
    endproperty
    property p_resv_with_take;
        resv_clear_out |-> taken_out;
    endproperty

    a_fetch_follows: assert property (p_fetch_follows) else $error("no fetch after take");
    a_ee_cleared: assert property (p_ee_cleared) else $error("irq enable kept");
    a_supervisor: assert property (p_supervisor) else $error("entry bits not cleared");
    a_vector_base: assert property (p_vector_base) else $error("wrong table base");
    a_kept_bits: assert property (p_kept_bits) else $error("kept bit changed");
    a_order_copy: assert property (p_order_copy) else $error("byte order not copied");
    a_nmi_taken: assert property (p_nmi_taken) else $error("unmaskable not taken");
    a_mchk_taken: assert property (p_mchk_taken) else $error("machine check not taken");
    a_checkstop_entry: assert property (p_checkstop_entry) else $error("no checkstop");
    a_checkstop_sticky: assert property (p_checkstop_sticky) else $error("left checkstop");
    a_earlier_blocks: assert property (p_earlier_blocks) else $error("taken past earlier");
    a_resv_with_take: assert property (p_resv_with_take) else $error("stray clear");

    c_take: cover property (taken_out);
    c_stop: cover property ($rose(checkstop_out));
    c_high: cover property (handler_fetch_out && msr_out[`MS_IP]);
endmodule

bind exception_entry_control exception_entry_control_checker exception_entry_control_checker_i (
    .*
);
`default_nettype wire

/* File: msr_entry.sv */
// New machine state value applied on exception entry
`timescale 1ns/1ps
`include "exc_cfg.svh"
`default_nettype none
module msr_entry (
    input  wire logic        is_reset_in,
    input  wire logic        strap_high_in,
    input  wire logic [31:0] old_in,
    output logic [31:0]      new_out
);
    // Reset loads a constant plus the strapped base; others edit the old value
    always_comb begin
        new_out = 32'h0000_0000;
        if (is_reset_in) begin
            new_out = `MS_RSTVAL;
            new_out[`MS_IP] = strap_high_in;
        end else begin
            // Untouched bits keep their value across entry
            new_out = old_in & ~`MS_CLRMASK;
            new_out[`MS_LE] = old_in[`MS_ILE];
        end
    end
endmodule
`default_nettype wire

/* File: tb_exception_entry_control.sv */
// Self-checking testbench for the exception entry control block
`timescale 1ns/1ps
`include "exc_cfg.svh"
`default_nettype none
module tb_exception_entry_control;
    logic              clk_sys_in;
    logic              srst_in;
    exc_pkg::bus_req_s bus_in;
    logic [31:0]       rdata_out;
    exc_pkg::cond_s    cond_in;
    logic              cfg_vector_high_in;
    logic              taken_out;
    logic              handler_fetch_out;
    logic [31:0]       handler_addr_out;
    logic              resv_clear_out;
    logic              checkstop_out;
    logic [31:0]       msr_out;
    logic              program_order_out;
    logic              little_endian_out;
    logic              fp_precise_out;
    logic              user_level_out;
    logic              ext_irq_enable_out;
    logic [4:0]        mode_pins;
    logic [31:0]       row_msr [9];
    logic [10:0]       row_cond [9];
    logic [31:0]       row_off [9];
    int                n_mismatch;
    int                tests_run;

    assign mode_pins = {program_order_out, little_endian_out, fp_precise_out, user_level_out,
                        ext_irq_enable_out};

    // Resume addresses and info are fixed so every entry has a known answer
    exception_entry_control exception_entry_control_i (
        .fault_pc_in(32'h0000_2000), .next_pc_in(32'h0000_3000),
        .instr_vec_off_in(32'h0000_0700), .exc_info_in(16'hA5C3), .*
    );

    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Bounded wait for taken (fetch=0) or handler fetch (fetch=1)
    task automatic wait_hi(input logic fetch);
        int n;
        n = 0;
        while (((fetch ? handler_fetch_out : taken_out) !== 1'b1) && n < 12) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        if ((fetch ? handler_fetch_out : taken_out) !== 1'b1) begin
            n_mismatch++;
            $display("mismatch wait expected 1 seen 0");
            test_done();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        bus_in.addr  <= a;
        bus_in.wdata <= d;
        bus_in.wr    <= 1'b1;
        @(posedge clk_sys_in);
        bus_in.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clk_sys_in);
        bus_in.addr <= a;
        bus_in.rd   <= 1'b1;
        @(posedge clk_sys_in);
        bus_in.rd <= 1'b0;
        #1;
        chk(name, exp, rdata_out);
    endtask

    task automatic do_reset(input logic strap);
        @(posedge clk_sys_in);
        srst_in            <= 1'b1;
        cfg_vector_high_in <= strap;
        repeat (10) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        #1;
        wait_hi(1'b1);
        chk("reset_vector", (strap ? `VB_HIGH : `VB_LOW) + `VO_RESET, handler_addr_out);
        rchk(`RA_MSTATE, `MS_RSTVAL | {25'h0, strap, 6'h0}, "reset_state");
        chk("checkstop", 32'h0, {31'h0, checkstop_out});
    endtask

    task automatic set_state(input logic [31:0] v);
        logic [4:0] ex;
        ex = {v[`MS_SE], v[`MS_LE], v[`MS_FE0] | v[`MS_FE1], v[`MS_PR], v[`MS_EE]};
        wr(`RA_MSTATE, v);
        #1;
        chk("mode_pins", {27'h0, ex}, {27'h0, mode_pins});
    endtask

    // One-cycle condition pulse, then the whole entry is compared
    task automatic entry(input logic [10:0] c, input logic [31:0] old, input logic [31:0] off);
        logic [31:0] base;
        logic [31:0] nxt;
        logic [31:0] pc;
        base = old[`MS_IP] ? `VB_HIGH : `VB_LOW;
        nxt  = (old & ~`MS_CLRMASK & ~32'h1) | {31'h0, old[`MS_ILE]};
        // Instruction-caused kinds resume at the faulting address
        pc   = (c[3] | c[4]) ? 32'h0000_2000 : 32'h0000_3000;
        @(posedge clk_sys_in);
        cond_in <= c;
        @(posedge clk_sys_in);
        cond_in <= '0;
        #1;
        wait_hi(1'b0);
        chk("resv_clear", {31'h0, c[0]}, {31'h0, resv_clear_out});
        @(posedge clk_sys_in);
        #1;
        chk("fetch", 32'h1, {31'h0, handler_fetch_out});
        chk("handler_addr", base + off, handler_addr_out);
        chk("new_state", nxt, msr_out);
        rchk(`RA_SRADDR, pc, "resume_addr");
        rchk(`RA_SRSTATE, {16'hA5C3, old[15:0]}, "resume_state");
    endtask

    // Hold a condition for 21 cycles and expect no entry in the first 20
    task automatic quiet(input logic [10:0] c, input string name);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        cond_in <= c;
        repeat (20) begin
            @(posedge clk_sys_in);
            #1;
            n += taken_out;
        end
        @(posedge clk_sys_in);
        cond_in <= '0;
        chk(name, 32'h0, 32'(n));
    endtask

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        n_mismatch = 0;
        tests_run  = 0;
        srst_in            <= 1'b1;
        bus_in             <= '0;
        cond_in            <= '0;
        cfg_vector_high_in <= 1'b1;
        row_msr  = '{32'h0001_0003, 32'h0000_1040, 32'h0001_0000, 32'h0000_0100, 32'h0000_0400,
                     32'h0000_0042, 32'h0001_8000, 32'h0001_FF03, 32'h0000_0000};
        row_cond = '{11'h080, 11'h100, 11'h008, 11'h010, 11'h004, 11'h060, 11'h401, 11'h200,
                     11'h020};
        row_off  = '{`VO_NMIBRK, `VO_MCHK, 32'h0000_0700, 32'h0000_0700, `VO_TRACE, `VO_BRK,
                     `VO_EXT, `VO_DECR, `VO_NMIBRK};
        do_reset(1'b1);
        rchk(`RA_DBGCTL, 32'h0, "debug_reset");
        wr(`RA_MSTATE, 32'hFFFF_FFFF);
        rchk(`RA_MSTATE, `MS_WMASK, "state_mask");
        wr(`RA_SRADDR, 32'h1234_5678);
        rchk(`RA_SRADDR, 32'h1234_5678, "resume_rw");
        rchk(8'h14, 32'h0, "unmapped");
        // Every non-reset kind in turn: unmaskable, machine check, instruction, float, trace, ...
        for (int i = 0; i < 9; i++) begin
            wr(`RA_DBGCTL, {31'h0, i == 8});
            set_state(row_msr[i]);
            entry(row_cond[i], row_msr[i], row_off[i]);
        end
        wr(`RA_DBGCTL, 32'h0);
        set_state(32'h0000_0000);
        quiet(11'h600, "irq_masked");
        quiet(11'h060, "brk_masked");
        quiet(11'h010, "fp_disabled");
        quiet(11'h004, "no_trace");
        quiet(11'h082, "earlier_pend");
        quiet(11'h100, "mchk_stop");
        chk("checkstop", 32'h1, {31'h0, checkstop_out});
        quiet(11'h080, "stopped");
        rchk(`RA_STATUS, 32'h0000_000D, "status");
        do_reset(1'b0);
        test_done();
    end
endmodule
`default_nettype wire
